// >>> rtl/dra_pkg.sv
// Package of constants for the display addressing command decoder
// Notes on behaviour
// - Command 00h-0Fh loads its low nibble into page-mode column start low nibble.
// - Command 10h-1Fh loads its low nibble into page-mode column start high nibble.
// - Command 20h takes one byte; low two bits 00b horizontal, 01b vertical.
// - Mode code 10b is page addressing, the mode after reset.
// - Command 21h takes column start then column end, each 0 to 127.
// - Column range resets to start 0, end 127.
// - Command 22h takes page start then page end, each 3 bits.
// - Page range resets to start 0, end 7.
// - Command B0h-B7h loads its low three bits as page-mode start page.
package dra_pkg;
  localparam logic [1:0] MODE_HORIZ = 2'h0;
  localparam logic [1:0] MODE_VERT = 2'h1;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [7:0] CMD_MODE = 8'h20;
  localparam logic [7:0] CMD_COLS = 8'h21;
  localparam logic [7:0] CMD_PAGES = 8'h22;
  localparam logic [3:0] GRP_COL_LO = 4'h0;
  localparam logic [3:0] GRP_COL_HI = 4'h1;
  localparam logic [4:0] GRP_PAGE_SET = 5'h16;
  localparam logic [6:0] COL_START_RST = 7'h00;
  localparam logic [6:0] COL_END_RST = 7'h7f;
  localparam logic [2:0] PAGE_START_RST = 3'h0;
  localparam logic [2:0] PAGE_END_RST = 3'h7;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  typedef enum logic [2:0] {
    DRA_IDLE = 3'b000,
    DRA_MODE_ARG = 3'b001,
    DRA_COL_A = 3'b010,
    DRA_COL_B = 3'b011,
    DRA_PAGE_A = 3'b100,
    DRA_PAGE_B = 3'b101
  } dra_state_t;
endpackage

// >>> rtl/dra_opcode_class.sv
// Single-byte opcode classifier for the addressing commands
`timescale 1ns/1ps
module dra_opcode_class
  import dra_pkg::*;
(
  // Command byte
  input wire logic [7:0] byte_i,
  // Classification
  output logic col_lo_o,
  output logic col_hi_o,
  output logic page_set_o
);
  always_comb begin
    col_lo_o = (byte_i[7:4] == GRP_COL_LO);
    col_hi_o = (byte_i[7:4] == GRP_COL_HI);
    page_set_o = (byte_i[7:3] == GRP_PAGE_SET);
  end
endmodule // dra_opcode_class

// >>> rtl/dra_addr_cmd.sv
// Addressing command decoder: mode, column and page pointers
`timescale 1ns/1ps
module dra_addr_cmd
  import dra_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Command byte stream, one byte per cycle while valid
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Addressing state
  output logic [1:0] addr_mode_o,
  output logic [6:0] col_start_o,
  output logic [6:0] col_end_o,
  output logic [2:0] page_start_o,
  output logic [2:0] page_end_o,
  output logic [3:0] pm_col_lo_o,
  output logic [3:0] pm_col_hi_o,
  output logic [2:0] pm_page_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  dra_state_t state_reg, state_next;
  logic [1:0] mode_reg, mode_next;
  logic [6:0] cs_reg, cs_next, ce_reg, ce_next;
  logic [2:0] ps_reg, ps_next, pe_reg, pe_next;
  logic [3:0] lo_reg, lo_next, hi_reg, hi_next;
  logic [2:0] pm_reg, pm_next;
  logic busy_reg, busy_next;
  logic is_lo, is_hi, is_pg;

  dra_opcode_class u_class (
    .byte_i(byte_i),
    .col_lo_o(is_lo),
    .col_hi_o(is_hi),
    .page_set_o(is_pg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Nibble and page commands are accepted in any mode; the host keeps to page mode
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    cs_next = cs_reg;
    ce_next = ce_reg;
    ps_next = ps_reg;
    pe_next = pe_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    pm_next = pm_reg;
    if (byte_valid_i) begin
      unique case (state_reg)
        DRA_IDLE: begin
          if (byte_i == CMD_MODE) state_next = DRA_MODE_ARG;
          else if (byte_i == CMD_COLS) state_next = DRA_COL_A;
          else if (byte_i == CMD_PAGES) state_next = DRA_PAGE_A;
          else if (is_lo) lo_next = byte_i[3:0];
          else if (is_hi) hi_next = byte_i[3:0];
          else if (is_pg) pm_next = byte_i[2:0];
        end
        DRA_MODE_ARG: begin
          // Invalid code keeps the old mode
          if (byte_i[1:0] != MODE_BAD) mode_next = byte_i[1:0];
          state_next = DRA_IDLE;
        end
        DRA_COL_A: begin
          cs_next = byte_i[6:0];
          state_next = DRA_COL_B;
        end
        DRA_COL_B: begin
          ce_next = byte_i[6:0];
          state_next = DRA_IDLE;
        end
        DRA_PAGE_A: begin
          ps_next = byte_i[2:0];
          state_next = DRA_PAGE_B;
        end
        DRA_PAGE_B: begin
          pe_next = byte_i[2:0];
          state_next = DRA_IDLE;
        end
        default: state_next = DRA_IDLE;
      endcase
    end
    // Busy is registered so that no output comes from a decode of state
    busy_next = (state_next != DRA_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= DRA_IDLE;
      mode_reg <= MODE_PAGE;
      cs_reg <= COL_START_RST;
      ce_reg <= COL_END_RST;
      ps_reg <= PAGE_START_RST;
      pe_reg <= PAGE_END_RST;
      lo_reg <= NIBBLE_RST;
      hi_reg <= NIBBLE_RST;
      pm_reg <= PAGE_START_RST;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cs_reg <= cs_next;
      ce_reg <= ce_next;
      ps_reg <= ps_next;
      pe_reg <= pe_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      pm_reg <= pm_next;
      busy_reg <= busy_next;
    end
  end

  assign addr_mode_o = mode_reg;
  assign col_start_o = cs_reg;
  assign col_end_o = ce_reg;
  assign page_start_o = ps_reg;
  assign page_end_o = pe_reg;
  assign pm_col_lo_o = lo_reg;
  assign pm_col_hi_o = hi_reg;
  assign pm_page_o = pm_reg;
  assign busy_o = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Argument capture
  mode_load_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_MODE_ARG && byte_valid_i && byte_i[1:0] != MODE_BAD
    |=> mode_reg == $past(byte_i[1:0]))
    else $error("mode not loaded");
  mode_bad_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_MODE_ARG && byte_valid_i && byte_i[1:0] == MODE_BAD
    |=> $stable(mode_reg))
    else $error("invalid mode changed state");
  mode_legal_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    mode_reg != MODE_BAD)
    else $error("illegal mode held");
  col_pair_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i == CMD_COLS
    ##1 byte_valid_i ##1 byte_valid_i
    |=> cs_reg == $past(byte_i[6:0], 2) && ce_reg == $past(byte_i[6:0]))
    else $error("column pair wrong");
  page_pair_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i == CMD_PAGES
    ##1 byte_valid_i ##1 byte_valid_i
    |=> ps_reg == $past(byte_i[2:0], 2) && pe_reg == $past(byte_i[2:0]))
    else $error("page pair wrong");
  nib_lo_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i[7:4] == GRP_COL_LO
    |=> lo_reg == $past(byte_i[3:0]) && $stable(hi_reg))
    else $error("low nibble wrong");
  nib_hi_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i[7:4] == GRP_COL_HI
    |=> hi_reg == $past(byte_i[3:0]) && $stable(lo_reg))
    else $error("high nibble wrong");
  pm_page_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i[7:3] == GRP_PAGE_SET
    |=> pm_reg == $past(byte_i[2:0]))
    else $error("page-mode page wrong");
  arg_stable_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_COL_A && byte_valid_i |=> $stable(lo_reg) && $stable(mode_reg))
    else $error("argument leaked to other state");

  // Registers that only their own command may move
  mode_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_MODE_ARG && byte_valid_i) |=> $stable(mode_reg))
    else $error("mode changed without argument");
  cstart_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_COL_A && byte_valid_i) |=> $stable(cs_reg))
    else $error("column start moved");
  cend_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_COL_B && byte_valid_i) |=> $stable(ce_reg))
    else $error("column end moved");
  pstart_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_PAGE_A && byte_valid_i) |=> $stable(ps_reg))
    else $error("page start moved");
  pend_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_PAGE_B && byte_valid_i) |=> $stable(pe_reg))
    else $error("page end moved");
  lo_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_IDLE && byte_valid_i && byte_i[7:4] == GRP_COL_LO) |=> $stable(lo_reg))
    else $error("low nibble moved");
  hi_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_IDLE && byte_valid_i && byte_i[7:4] == GRP_COL_HI) |=> $stable(hi_reg))
    else $error("high nibble moved");
  pm_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(state_reg == DRA_IDLE && byte_valid_i && byte_i[7:3] == GRP_PAGE_SET) |=> $stable(pm_reg))
    else $error("page-mode page moved");
  arg_not_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_PAGE_B && byte_valid_i
    |=> $stable(lo_reg) && $stable(hi_reg) && $stable(pm_reg))
    else $error("parameter decoded as command");

  // Sequencing of the parameter bytes
  mode_enter_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i == CMD_MODE |=> state_reg == DRA_MODE_ARG)
    else $error("mode command not taken");
  col_enter_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i == CMD_COLS |=> state_reg == DRA_COL_A)
    else $error("column command not taken");
  page_enter_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_IDLE && byte_valid_i && byte_i == CMD_PAGES |=> state_reg == DRA_PAGE_A)
    else $error("page command not taken");
  col_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_COL_A && byte_valid_i |=> state_reg == DRA_COL_B)
    else $error("column end not awaited");
  page_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_PAGE_A && byte_valid_i |=> state_reg == DRA_PAGE_B)
    else $error("page end not awaited");
  mode_exit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_MODE_ARG && byte_valid_i |=> state_reg == DRA_IDLE)
    else $error("mode argument not closed");
  col_exit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_COL_B && byte_valid_i |=> state_reg == DRA_IDLE)
    else $error("column command not closed");
  page_exit_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg == DRA_PAGE_B && byte_valid_i |=> state_reg == DRA_IDLE)
    else $error("page command not closed");
  arg_wait_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_reg != DRA_IDLE && !byte_valid_i |=> $stable(state_reg))
    else $error("pending argument dropped");
  busy_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    busy_o == (state_reg != DRA_IDLE))
    else $error("busy flag out of step");
endmodule // dra_addr_cmd

// >>> test/dra_host_model.sv
// Host model feeding command and parameter bytes
`timescale 1ns/1ps
module dra_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Byte stream
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // Valid stays up after a byte so calls may run back to back
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk_i);
    byte_valid_o = 1'b1;
    byte_o = b;
  endtask
  // A released bus shows the inverse of the last byte, never a stale copy
  task automatic gap();
    @(negedge ref_clk_i);
    byte_valid_o = 1'b0;
    byte_o = ~byte_o;
  endtask
endmodule // dra_host_model

// >>> test/dra_addr_cmd_test.sv
// Self-checking bench for the addressing command decoder
`timescale 1ns/1ps
module dra_addr_cmd_test;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic byte_valid_i;
  logic [7:0] byte_i;
  logic [1:0] addr_mode_o;
  logic [6:0] col_start_o, col_end_o;
  logic [2:0] page_start_o, page_end_o, pm_page_o;
  logic [3:0] pm_col_lo_o, pm_col_hi_o;
  logic busy_o;
  int fail_count = 0, check_count = 0, cyc = 0;
  int md = 2, cs = 0, ce = 127, ps = 0, pe = 7, lo = 0, hi = 0, pg = 0, st = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  dra_host_model host (.ref_clk_i(ref_clk_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i));
  dra_addr_cmd uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .addr_mode_o(addr_mode_o), .col_start_o(col_start_o),
    .col_end_o(col_end_o), .page_start_o(page_start_o), .page_end_o(page_end_o),
    .pm_col_lo_o(pm_col_lo_o), .pm_col_hi_o(pm_col_hi_o), .pm_page_o(pm_page_o),
    .busy_o(busy_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input int exp);
    check_count++;
    if (got !== exp[7:0]) begin
      fail_count++;
      $display("[ERR] %0t: got %0h want %0h", $time, got, exp[7:0]);
    end
  endtask
  task automatic check_all();
    cmp(addr_mode_o, md);
    cmp(col_start_o, cs);
    cmp(col_end_o, ce);
    cmp(page_start_o, ps);
    cmp(page_end_o, pe);
    cmp(pm_col_lo_o, lo);
    cmp(pm_col_hi_o, hi);
    cmp(pm_page_o, pg);
    cmp(busy_o, int'(st != 0));
  endtask
  // Reference model steps on every byte, then the outputs are compared
  task automatic put(input logic [7:0] b);
    case (st)
      1: begin if (b[1:0] != 2'h3) md = b[1:0]; st = 0; end
      2: begin cs = b[6:0]; st = 3; end
      3: begin ce = b[6:0]; st = 0; end
      4: begin ps = b[2:0]; st = 5; end
      5: begin pe = b[2:0]; st = 0; end
      default: begin
        if (b < 8'h10) lo = b[3:0];
        else if (b < 8'h20) hi = b[3:0];
        else if (b[7:3] == 5'h16) pg = b[2:0];
        st = (b == 8'h20) ? 1 : (b == 8'h21) ? 2 : (b == 8'h22) ? 4 : 0;
      end
    endcase
    host.send(b);
    @(posedge ref_clk_i);
    #1 check_all();
  endtask
  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h4456));
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i) resetn_i = 1'b1;
    check_all();
    // Page mode holds here, so nibble and page-start commands are legal
    for (int i = 0; i < 32; i++) put(i[7:0]);
    for (int i = 0; i < 8; i++) put(8'hb0 + i[7:0]);
    for (int i = 0; i < 24; i++) begin
      put(8'h20);
      put({rb() & 8'hfc} | {7'h00, i[0]});
      // Ranges only while horizontal or vertical; a gap sometimes splits the pair
      put(8'h21);
      put(rb());
      if (i[1]) host.gap();
      put(rb());
      put(8'h22);
      put(rb());
      put(rb());
      // The invalid code is sent on purpose here and must be ignored
      if (i % 4 == 3) begin
        put(8'h20);
        put(rb() | 8'h03);
      end
    end
    put(8'h20);
    put(8'h02);
    for (int i = 0; i < 60; i++) put(rb() & 8'h1f | (i[0] ? 8'hb0 : 8'h00));
    // Reset in mid-sequence: the pending page end must be forgotten
    put(8'h20);
    put(8'h00);
    put(8'h22);
    put(8'h05);
    host.gap();
    @(negedge ref_clk_i) resetn_i = 1'b0;
    md = 2;
    cs = 0;
    ce = 127;
    ps = 0;
    pe = 7;
    lo = 0;
    hi = 0;
    pg = 0;
    st = 0;
    #1 check_all();
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i) resetn_i = 1'b1;
    check_all();
    put(8'h0a);
    put(8'h12);
    host.gap();
    end_of_test();
  end
endmodule // dra_addr_cmd_test
